// [verilog/cfie_map.svh]
// Offsets, field positions, reset values and limits of the CPU inject/extract block
`ifndef CFIE_MAP_SVH
`define CFIE_MAP_SVH
// Register byte offsets
`define CFIE_A_QCFG 6'h00
`define CFIE_A_SCMASK 6'h20
`define CFIE_A_GRP 6'h24
`define CFIE_A_STAT 6'h28
`define CFIE_A_XDATA 6'h2C
`define CFIE_A_XFLAG 6'h30
`define CFIE_A_IHDR0 6'h34
`define CFIE_A_IHDR1 6'h38
// Queue map entry fields
`define CFIE_Q_PORT 3:0
`define CFIE_Q_CPE 4
`define CFIE_Q_PRIO 7:5
// Group configuration fields
`define CFIE_G_MODE 0
`define CFIE_G_THR 6:4
// Injection header fields
`define CFIE_H_PT 2:0
`define CFIE_H_MASQ 3
`define CFIE_H_MODE 4
`define CFIE_H_DEST 8:5
`define CFIE_H_SRC 12:9
`define CFIE_H_AUTO 13
`define CFIE_H_ENC 21:14
`define CFIE_H_PMASK 31:22
// Reset values
`define CFIE_QCFG_RST 8'h0A
`define CFIE_SCMASK_RST 8'hFF
`define CFIE_THR_RST 3'h4
// Constants
`define CFIE_CPU_PORT0 4'hA
`define CFIE_PT_BYPASS_ALL 3'h7
`define CFIE_SBH_LAST 3'h6
`define CFIE_QDEPTH 3'h4
`endif

// [verilog/cfie_pkg.sv]
// Types of the CPU inject/extract block
package cfie_pkg;
  // Extraction header sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_PHDR, SQ_SBH} cfie_seq_type;
  // Queued descriptor: reason, classification, frame id
  typedef logic [55:0] cfie_desc_type;
  // Stream word: port, last flag, data
  typedef logic [36:0] cfie_word_type;
endpackage

// [verilog/cfie_top.sv]
// CPU frame injection and extraction core
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "cfie_map.svh"

//Behaviour
//RL1: Eight extraction queues, each mapped by its entry to a CPU or front port.
//RL2: Each queue may use a programmed egress priority when copy priority is enabled.
//RL3: Per port, next frame chosen by strict priority among its queues.
//RL4: Two injection groups forward into the analyzer in parallel.
//RL5: Injection and extraction reachable by DMA stream and by register access.
//RL6: Injected frames skip every stage before the named inject point.
//RL7: Analyzer done point bypasses analyzer; destination comes from header field.
//RL8: Unicast goes to one named port with encapsulation carried when selected.
//RL9: Multicast goes to port mask, encapsulation forced zero, analyzer bypassed.
//RL10: Masqueraded frames are processed as received on the masquerade source port; for multicast the core keeps ANA_SRC but clears ANA_MASQ.
//RL11: Several queues selected: only highest copy unless single-copy mask clears it.
//RL12: Every extracted frame gets a 28-byte side-band header ahead.
//RL13: Group mode adds a 4-byte port header ahead of the side-band header.
//RL14: Queues obey CPU threshold and shared queue system room.
//RL15: Rewriter and up-endpoint copies loop back through the analyzer.
//RL16: Auto-inject flag hands the frame to the automatic injector.
//RL17: Automatic injector frames go direct to egress or masqueraded.
//RL18: Side-band header carries classification and extraction reason.
//RL19: Each queue delivers frames in arrival order.
module cfie_top
  import cfie_pkg::*;
(
  // Clock and reset
  input logic CLK_SYS,
  input logic SYS_RST,
  // Register port
  input logic [5:0] REG_ADDR,
  input logic [31:0] REG_WDATA,
  input logic REG_WR,
  input logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Extraction requests from the forwarding logic
  input logic XTR_REQ,
  input logic [7:0] XTR_QMASK,
  input logic [31:0] XTR_CLASS,
  input logic [7:0] XTR_REASON,
  input logic [15:0] XTR_FRAME_ID,
  input logic SHARED_OK,
  output logic XTR_DROP,
  // Extraction stream to the frame DMA
  output logic DMA_VALID,
  output logic [31:0] DMA_DATA,
  output logic DMA_LAST,
  output logic [3:0] DMA_PORT,
  input logic DMA_READY,
  // Injection: groups 0 and 1, index 2 is the automatic injector
  input logic [2:0] INJ_VALID,
  input logic [95:0] INJ_HDR,
  output logic [2:0] ANA_VALID,
  output logic [23:0] ANA_SKIP,
  output logic [2:0] ANA_BYPASS,
  output logic [35:0] ANA_DEST,
  output logic [11:0] ANA_SRC,
  output logic [23:0] ANA_ENCOPS,
  output logic [2:0] ANA_MASQ,
  output logic [1:0] AUTO_TAKE,
  // Loop back of rewriter and up-endpoint copies
  input logic LOOP_VALID,
  input logic [15:0] LOOP_ID,
  output logic REANA_VALID,
  output logic [15:0] REANA_ID
);
  import cfie_pkg::*;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] qcfg_q [8];
  logic [7:0] scmask_q;
  logic [7:0] grp_q;
  logic [15:0] drops_q;
  logic [31:0] ihdr_q [2];
  logic [1:0] igo_q;
  logic [31:0] rdata_q;
  wire wr_qcfg = REG_WR & ~REG_ADDR[5];
  wire wr_scm = REG_WR & (REG_ADDR == `CFIE_A_SCMASK);
  wire wr_grp = REG_WR & (REG_ADDR == `CFIE_A_GRP);
  wire wr_ih0 = REG_WR & (REG_ADDR == `CFIE_A_IHDR0);
  wire wr_ih1 = REG_WR & (REG_ADDR == `CFIE_A_IHDR1);
  wire xtr_rd = REG_RD & (REG_ADDR == `CFIE_A_XDATA);
  wire [2:0] thr = grp_q[`CFIE_G_THR];

  // Configuration writes
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < 8; i++)
        qcfg_q[i] <= `CFIE_QCFG_RST;
      scmask_q <= `CFIE_SCMASK_RST;
      grp_q <= {1'b0, `CFIE_THR_RST, 4'h0};
    end
    else
    begin
      if (wr_qcfg)
        qcfg_q[REG_ADDR[4:2]] <= REG_WDATA[7:0]; // RL1 RL2
      if (wr_scm)
        scmask_q <= REG_WDATA[7:0];
      if (wr_grp)
        grp_q <= {1'b0, REG_WDATA[6:4], 3'h0, REG_WDATA[0]};
    end
  end

  // ************************************************************
  // Extraction queues
  // ************************************************************
  logic [7:0] nonempty;
  logic [7:0] room;
  logic [7:0] same_last;
  logic [2:0] eff_prio [8];
  cfie_desc_type qhead [8];
  logic [7:0] q_pop;
  logic [3:0] last_port_q;

  // Copy selection: masked queues keep only the highest one
  wire [7:0] one_set = XTR_QMASK & scmask_q;
  logic [7:0] top_one;
  always_comb
  begin
    top_one = 8'h00;
    for (int i = 0; i < 8; i++)
      if (one_set[i])
        top_one = 8'h01 << i; // RL11
  end
  wire [7:0] enq_sel = XTR_REQ ? ((XTR_QMASK & ~scmask_q) | top_one) : 8'h00;
  wire [7:0] enq = enq_sel & room;
  wire drop_ev = |(enq_sel & ~room);

  // Drop counter and drop pulse
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      drops_q <= 16'h0000;
      XTR_DROP <= 1'b0;
    end
    else
    begin
      XTR_DROP <= drop_ev; // RL14
      if (drop_ev)
        drops_q <= drops_q + 16'h0001;
    end
  end

  // One FIFO of descriptors per queue
  generate
    for (genvar g = 0; g < 8; g++)
    begin : g_q
      cfie_desc_type mem [4];
      logic [1:0] wp_q;
      logic [1:0] rp_q;
      logic [2:0] cnt_q;
      assign nonempty[g] = cnt_q != 3'h0;
      assign room[g] = SHARED_OK & (cnt_q < thr) & (cnt_q < `CFIE_QDEPTH); // RL14
      assign qhead[g] = mem[rp_q];
      assign same_last[g] = qcfg_q[g][`CFIE_Q_PORT] == last_port_q;
      assign eff_prio[g] = qcfg_q[g][`CFIE_Q_CPE] ? qcfg_q[g][`CFIE_Q_PRIO] : 3'(g); // RL2
      // Pointers and storage, first in first out
      always_ff @(posedge CLK_SYS)
      begin
        if (SYS_RST)
        begin
          wp_q <= 2'h0;
          rp_q <= 2'h0;
          cnt_q <= 3'h0;
        end
        else
        begin
          if (enq[g])
          begin
            mem[wp_q] <= {XTR_REASON, XTR_CLASS, XTR_FRAME_ID};
            wp_q <= wp_q + 2'h1;
          end
          if (q_pop[g])
            rp_q <= rp_q + 2'h1; // RL19
          cnt_q <= cnt_q + {2'h0, enq[g]} - {2'h0, q_pop[g]};
        end
      end
    end
  endgenerate

  // ************************************************************
  // Port selection
  // ************************************************************
  wire other_any = |(nonempty & ~same_last);
  wire [7:0] cand = nonempty & (other_any ? ~same_last : 8'hFF);
  logic best_v;
  logic [5:0] best_k;
  logic [2:0] best_q;
  // Highest priority among candidates; a port's queues compete strictly
  always_comb
  begin
    best_v = 1'b0;
    best_k = 6'h00;
    best_q = 3'h0;
    for (int i = 0; i < 8; i++)
      if (cand[i] && (!best_v || {eff_prio[i], 3'(i)} > best_k))
      begin
        best_v = 1'b1;
        best_k = {eff_prio[i], 3'(i)}; // RL3
        best_q = 3'(i);
      end
  end

  // ************************************************************
  // Header sequencer
  // ************************************************************
  cfie_seq_type st_q;
  cfie_desc_type cur_q;
  logic [2:0] curq_q;
  logic [3:0] port_q;
  logic [2:0] idx_q;
  logic tv_q;
  wire start = (st_q == SQ_IDLE) & best_v;
  assign q_pop = start ? (8'h01 << best_q) : 8'h00;
  wire push = (st_q != SQ_IDLE) & ~tv_q;
  wire [31:0] sbh_w = (idx_q == 3'h0) ? cur_q[47:16] :
                      (idx_q == 3'h1) ? {16'h0000, cur_q[55:48], 5'h00, curq_q} :
                      (idx_q == 3'h2) ? {16'h0000, cur_q[15:0]} : 32'h0000_0000; // RL18
  wire is_last = (st_q == SQ_SBH) & (idx_q == `CFIE_SBH_LAST);
  wire [31:0] pw_data = (st_q == SQ_PHDR) ? {28'h000_0000, port_q} : sbh_w; // RL13
  wire [36:0] pw = {port_q, is_last, pw_data};

  // Sequencer: optional port word, then seven side-band words
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      st_q <= SQ_IDLE;
      cur_q <= '0;
      curq_q <= 3'h0;
      port_q <= 4'h0;
      idx_q <= 3'h0;
      last_port_q <= 4'h0;
    end
    else
    begin
      unique case (st_q)
        SQ_IDLE:
          if (start)
          begin
            cur_q <= qhead[best_q];
            curq_q <= best_q;
            port_q <= qcfg_q[best_q][`CFIE_Q_PORT]; // RL1
            last_port_q <= qcfg_q[best_q][`CFIE_Q_PORT];
            idx_q <= 3'h0;
            st_q <= grp_q[`CFIE_G_MODE] ? SQ_PHDR : SQ_SBH; // RL13
          end
        SQ_PHDR:
          if (push)
            st_q <= SQ_SBH;
        SQ_SBH:
          if (push)
          begin
            idx_q <= idx_q + 3'h1;
            if (is_last)
              st_q <= SQ_IDLE; // RL12
          end
      endcase
    end
  end

  // ************************************************************
  // Two-entry output buffer
  // ************************************************************
  cfie_word_type hd_q;
  cfie_word_type td_q;
  logic hv_q;
  wire pop = hv_q & (DMA_READY | xtr_rd); // RL5
  // Head always holds the oldest word, tail takes overflow
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      hv_q <= 1'b0;
      tv_q <= 1'b0;
      hd_q <= '0;
      td_q <= '0;
    end
    else if (pop | ~hv_q)
    begin
      hv_q <= tv_q | push;
      hd_q <= tv_q ? td_q : pw;
      tv_q <= 1'b0;
    end
    else if (push)
    begin
      tv_q <= 1'b1;
      td_q <= pw;
    end
  end
  assign DMA_VALID = hv_q;
  assign DMA_DATA = hd_q[31:0];
  assign DMA_LAST = hd_q[32];
  assign DMA_PORT = hd_q[36:33];

  // ************************************************************
  // Register read and register injection
  // ************************************************************
  // Flags read zero while the buffer is empty, like the data word
  wire [31:0] xflag_w = hv_q ? {26'h000_0000, hd_q[36:33], hd_q[32], 1'b1} : 32'h0000_0000;
  wire [31:0] rd_mux = ~REG_ADDR[5] ? {24'h00_0000, qcfg_q[REG_ADDR[4:2]]} :
                       (REG_ADDR == `CFIE_A_SCMASK) ? {24'h00_0000, scmask_q} :
                       (REG_ADDR == `CFIE_A_GRP) ? {24'h00_0000, grp_q} :
                       (REG_ADDR == `CFIE_A_STAT) ? {8'h00, nonempty, drops_q} :
                       (REG_ADDR == `CFIE_A_XDATA) ? (hv_q ? hd_q[31:0] : 32'h0000_0000) :
                       (REG_ADDR == `CFIE_A_XFLAG) ? xflag_w :
                       (REG_ADDR == `CFIE_A_IHDR0) ? ihdr_q[0] :
                       (REG_ADDR == `CFIE_A_IHDR1) ? ihdr_q[1] : 32'h0000_0000;

  // Read data one cycle after the strobe; header writes arm an injection
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      rdata_q <= 32'h0000_0000;
      ihdr_q[0] <= 32'h0000_0000;
      ihdr_q[1] <= 32'h0000_0000;
      igo_q <= 2'b00;
    end
    else
    begin
      rdata_q <= REG_RD ? rd_mux : 32'h0000_0000;
      if (wr_ih0)
        ihdr_q[0] <= REG_WDATA;
      if (wr_ih1)
        ihdr_q[1] <= REG_WDATA;
      igo_q[0] <= wr_ih0 | (igo_q[0] & INJ_VALID[0]); // RL5
      igo_q[1] <= wr_ih1 | (igo_q[1] & INJ_VALID[1]);
    end
  end
  assign REG_RDATA = rdata_q;

  // ************************************************************
  // Injection decode, one per source
  // ************************************************************
  generate
    for (genvar k = 0; k < 3; k++)
    begin : g_inj
      logic [31:0] hdr;
      logic v;
      logic av_q;
      logic by_q;
      logic mq_q;
      logic [7:0] sk_q;
      logic [11:0] ds_q;
      logic [3:0] sr_q;
      logic [7:0] en_q;
      if (k < 2)
      begin : g_grp
        assign hdr = INJ_VALID[k] ? INJ_HDR[32*k +: 32] : ihdr_q[k];
        assign v = INJ_VALID[k] | igo_q[k];
      end
      else
      begin : g_auto
        assign hdr = INJ_HDR[64 +: 32];
        assign v = INJ_VALID[2];
      end
      wire [2:0] pt = hdr[`CFIE_H_PT];
      wire masq = hdr[`CFIE_H_MASQ];
      wire mc = hdr[`CFIE_H_MODE];
      wire to_auto = (k < 2) & hdr[`CFIE_H_AUTO]; // RL16
      wire done = pt == `CFIE_PT_BYPASS_ALL;
      wire [7:0] skip = (8'h01 << pt) - 8'h01; // RL6
      wire [11:0] dest = mc ? {2'b00, hdr[`CFIE_H_PMASK]} : (12'h001 << hdr[`CFIE_H_DEST]); // RL8 RL9
      wire bypass = mc | done | ((k == 2) & ~masq); // RL7 RL9 RL17
      wire [7:0] enc = mc ? 8'h00 : hdr[`CFIE_H_ENC]; // RL9
      wire [3:0] src = masq ? hdr[`CFIE_H_SRC] : `CFIE_CPU_PORT0 + 4'(k); // RL10
      // Registered analyzer request, parallel for every source
      always_ff @(posedge CLK_SYS)
      begin
        if (SYS_RST)
        begin
          av_q <= 1'b0;
          by_q <= 1'b0;
          mq_q <= 1'b0;
          sk_q <= 8'h00;
          ds_q <= 12'h000;
          sr_q <= 4'h0;
          en_q <= 8'h00;
        end
        else
        begin
          av_q <= v & ~to_auto; // RL4
          by_q <= bypass;
          mq_q <= masq & ~mc;
          sk_q <= skip;
          ds_q <= dest;
          sr_q <= src;
          en_q <= enc;
        end
      end
      assign ANA_VALID[k] = av_q;
      assign ANA_BYPASS[k] = by_q;
      assign ANA_MASQ[k] = mq_q;
      assign ANA_SKIP[8*k +: 8] = sk_q;
      assign ANA_DEST[12*k +: 12] = ds_q;
      assign ANA_SRC[4*k +: 4] = sr_q;
      assign ANA_ENCOPS[8*k +: 8] = en_q;
    end
  endgenerate

  // ************************************************************
  // Automatic injector hand-off and loop back
  // ************************************************************
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      AUTO_TAKE <= 2'b00;
      REANA_VALID <= 1'b0;
      REANA_ID <= 16'h0000;
    end
    else
    begin
      AUTO_TAKE[0] <= g_inj[0].v & g_inj[0].to_auto; // RL16
      AUTO_TAKE[1] <= g_inj[1].v & g_inj[1].to_auto;
      REANA_VALID <= LOOP_VALID; // RL15
      REANA_ID <= LOOP_ID;
    end
  end
endmodule

// [testbench/cfie_top_chk.sv]
// Port assertions of the CPU inject/extract core
`timescale 1ns/1ps
`include "cfie_map.svh"
module cfie_top_chk
(
  // Clock and reset
  input logic CLK_SYS,
  input logic SYS_RST,
  // Register port
  input logic [5:0] REG_ADDR,
  input logic REG_RD,
  input logic [31:0] REG_RDATA,
  // Extraction
  input logic XTR_REQ,
  input logic [7:0] XTR_QMASK,
  input logic SHARED_OK,
  input logic XTR_DROP,
  input logic DMA_VALID,
  input logic [31:0] DMA_DATA,
  input logic DMA_READY,
  // Injection and loop back
  input logic [2:0] INJ_VALID,
  input logic [95:0] INJ_HDR,
  input logic [2:0] ANA_VALID,
  input logic [23:0] ANA_SKIP,
  input logic [2:0] ANA_BYPASS,
  input logic [35:0] ANA_DEST,
  input logic [11:0] ANA_SRC,
  input logic [23:0] ANA_ENCOPS,
  input logic [2:0] ANA_MASQ,
  input logic [1:0] AUTO_TAKE,
  input logic LOOP_VALID,
  input logic [15:0] LOOP_ID,
  input logic REANA_VALID,
  input logic [15:0] REANA_ID
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // Group 0 strobe aimed at the analyzer
  wire g0 = INJ_VALID[0] && !INJ_HDR[13];
  wire xpop = REG_RD && (REG_ADDR == `CFIE_A_XDATA);
  // ****************************************
  // Assertions
  // ****************************************
  chk_rd_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0000_0000)
    else $error("read data not zero outside a read");
  chk_dma_hold: assert property (DMA_VALID && !DMA_READY && !xpop |=>
    DMA_VALID && $stable(DMA_DATA)) else $error("stalled word lost");
  chk_drop_full: assert property (XTR_REQ && !SHARED_OK && XTR_QMASK != 8'h00
    |=> XTR_DROP) else $error("no drop without shared room");
  chk_uc_dest: assert property (g0 && INJ_HDR[4:3] == 2'b00 |=> ANA_VALID[0] &&
    ANA_DEST[11:0] == (12'h001 << $past(INJ_HDR[8:5])) &&
    ANA_ENCOPS[7:0] == $past(INJ_HDR[21:14])) else $error("unicast request wrong");
  chk_mc_mask: assert property (INJ_VALID[1] && INJ_HDR[36] && !INJ_HDR[45] |=>
    ANA_ENCOPS[15:8] == 8'h00 && ANA_BYPASS[1] && ANA_DEST[21:12] == $past(INJ_HDR[63:54]))
    else $error("multicast request wrong");
  chk_skip_pt: assert property (INJ_VALID[1] && !INJ_HDR[45] |=>
    ANA_SKIP[15:8] == (8'h01 << $past(INJ_HDR[34:32])) - 8'h01)
    else $error("skipped stages wrong");
  chk_bypass_g0: assert property (g0 |=> ANA_BYPASS[0] ==
    ($past(INJ_HDR[4]) || $past(INJ_HDR[2:0]) == `CFIE_PT_BYPASS_ALL))
    else $error("bypass wrong");
  chk_masq_src: assert property (g0 && INJ_HDR[3] |=> ANA_MASQ[0] &&
    ANA_SRC[3:0] == $past(INJ_HDR[12:9])) else $error("masquerade source wrong");
  chk_auto_take: assert property (INJ_VALID[1] && INJ_HDR[45] |=> AUTO_TAKE[1])
    else $error("auto inject not taken");
  chk_auto_out: assert property (INJ_VALID[2] && !INJ_HDR[67] |=>
    ANA_VALID[2] && ANA_BYPASS[2]) else $error("direct replay not bypassed");
  chk_loop_back: assert property (LOOP_VALID |=> REANA_VALID &&
    REANA_ID == $past(LOOP_ID)) else $error("loop copy not re-analysed");
endmodule

bind cfie_top cfie_top_chk chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
  .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .XTR_REQ(XTR_REQ),
  .XTR_QMASK(XTR_QMASK), .SHARED_OK(SHARED_OK), .XTR_DROP(XTR_DROP),
  .DMA_VALID(DMA_VALID), .DMA_DATA(DMA_DATA), .DMA_READY(DMA_READY),
  .INJ_VALID(INJ_VALID), .INJ_HDR(INJ_HDR), .ANA_VALID(ANA_VALID), .ANA_SKIP(ANA_SKIP),
  .ANA_BYPASS(ANA_BYPASS), .ANA_DEST(ANA_DEST), .ANA_SRC(ANA_SRC),
  .ANA_ENCOPS(ANA_ENCOPS), .ANA_MASQ(ANA_MASQ), .AUTO_TAKE(AUTO_TAKE),
  .LOOP_VALID(LOOP_VALID), .LOOP_ID(LOOP_ID), .REANA_VALID(REANA_VALID),
  .REANA_ID(REANA_ID));

// [testbench/cfie_dma_host.sv]
// Frame DMA model that takes extraction words and can stall
`timescale 1ns/1ps
module cfie_dma_host
(
  // Clock and reset
  input logic clk,
  input logic rst,
  // Bench control
  input logic stall,
  input logic slow,
  // Extraction stream
  input logic valid,
  input logic [31:0] data,
  input logic last,
  input logic [3:0] port,
  output logic ready
);
  logic ph_q;
  logic [36:0] got [0:63];
  int n;
  // Ready pattern: prompt, every other cycle, or held off
  always_ff @(posedge clk)
  begin
    ph_q <= rst ? 1'b0 : !ph_q;
  end
  assign ready = !stall && (!slow || ph_q);
  // Store each word that is taken
  always_ff @(posedge clk)
  begin
    if (rst)
      n <= 0;
    else if (valid && ready)
    begin
      got[n[5:0]] <= {port, last, data};
      n <= n + 1;
    end
  end
endmodule

// [testbench/testbench.sv]
// Self-checking bench of the CPU inject/extract core
`timescale 1ns/1ps
module testbench;
  logic clk = 0;
  logic rst = 1;
  logic [5:0] ra = 0;
  logic [31:0] wd = 0;
  logic wr = 0;
  logic rd = 0;
  logic [31:0] rdat, dd, t;
  logic xr = 0;
  logic [7:0] qm = 0;
  logic [31:0] cl = 0;
  logic [7:0] rs = 0;
  logic [15:0] id = 0;
  logic sok = 1;
  logic drop, dv, dl, rdy, rv;
  logic [3:0] dp;
  logic [2:0] iv = 0;
  logic [95:0] ih = 0;
  logic [2:0] av, ab, am;
  logic [23:0] ask, aen;
  logic [35:0] ad;
  logic [11:0] asr;
  logic [1:0] at;
  logic lv = 0;
  logic [15:0] li = 0;
  logic [15:0] ri;
  logic stall = 0;
  logic slow = 0;
  int error_cnt = 0;
  int n_tests = 0;
  // Clock of 100 ns
  always #50 clk = !clk;
  cfie_top dut (.CLK_SYS(clk), .SYS_RST(rst), .REG_ADDR(ra), .REG_WDATA(wd),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .XTR_REQ(xr), .XTR_QMASK(qm),
    .XTR_CLASS(cl), .XTR_REASON(rs), .XTR_FRAME_ID(id), .SHARED_OK(sok),
    .XTR_DROP(drop), .DMA_VALID(dv), .DMA_DATA(dd), .DMA_LAST(dl), .DMA_PORT(dp),
    .DMA_READY(rdy), .INJ_VALID(iv), .INJ_HDR(ih), .ANA_VALID(av), .ANA_SKIP(ask),
    .ANA_BYPASS(ab), .ANA_DEST(ad), .ANA_SRC(asr), .ANA_ENCOPS(aen), .ANA_MASQ(am),
    .AUTO_TAKE(at), .LOOP_VALID(lv), .LOOP_ID(li), .REANA_VALID(rv), .REANA_ID(ri));
  cfie_dma_host host (.clk(clk), .rst(rst), .stall(stall), .slow(slow), .valid(dv),
    .data(dd), .last(dl), .port(dp), .ready(rdy));
  // Compare one word
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
  begin
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  // Register write and read cycles
  task automatic wrr(input logic [5:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    wr <= 1;
    ra <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
  end
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
  begin
    @(posedge clk);
    rd <= 1;
    ra <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdat, e);
  end
  endtask
  // Extraction request; class and reason follow the frame handle
  task automatic xtr(input logic [7:0] m, input logic [15:0] i);
  begin
    @(posedge clk);
    xr <= 1;
    qm <= m;
    cl <= {16'hC1A5, i};
    rs <= i[7:0] + 8'h40;
    id <= i;
    @(posedge clk);
    xr <= 0;
  end
  endtask
  // Side-band words of one frame as stored by the host
  task automatic frm(input int b, input logic [2:0] q, input logic [15:0] i);
  begin
    chk(host.got[b][31:0], {16'hC1A5, i});
    chk(host.got[b+1][31:0], {16'h0000, i[7:0] + 8'h40, 5'h00, q});
    chk(host.got[b+2][31:0], {16'h0000, i});
    chk({27'h0, host.got[b+6][36:32]}, {27'h0, 4'hA, 1'b1});
  end
  endtask
  // Bounded wait for a word count
  task automatic waitn(input int k);
  begin
    repeat (200)
    begin
      if (host.n < k)
        @(posedge clk);
    end
    chk(host.n, k);
  end
  endtask
  // Injection strobes for all three sources
  task automatic inj(input logic [2:0] v, input logic [95:0] h);
  begin
    @(posedge clk);
    iv <= v;
    ih <= h;
    @(posedge clk);
    iv <= 0;
    #1;
  end
  endtask
  task automatic end_of_test;
  begin
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rc(6'h00, 32'h0000_000A);
    rc(6'h20, 32'h0000_00FF);
    rc(6'h24, 32'h0000_0040);
    wrr(6'h28, 32'hFFFF_FFFF);
    rc(6'h28, 32'h0000_0000);
    rc(6'h3C, 32'h0000_0000);
    $display("test regs done");
    xtr(8'h0C, 16'h0001);
    waitn(7);
    frm(0, 3'h3, 16'h0001);
    wrr(6'h20, 32'h0000_0000);
    xtr(8'h0C, 16'h0002);
    waitn(21);
    frm(7, 3'h3, 16'h0002);
    frm(14, 3'h2, 16'h0002);
    wrr(6'h20, 32'h0000_00FF);
    $display("test copies done");
    stall <= 1;
    wrr(6'h04, 32'h0000_00FA);
    xtr(8'h01, 16'h0003);
    xtr(8'h40, 16'h0004);
    xtr(8'h40, 16'h0005);
    xtr(8'h02, 16'h0006);
    repeat (20) @(posedge clk);
    chk({31'h0, dv}, 32'h1);
    chk(host.n, 21);
    slow <= 1;
    stall <= 0;
    waitn(49);
    frm(21, 3'h0, 16'h0003);
    frm(28, 3'h1, 16'h0006);
    frm(35, 3'h6, 16'h0004);
    frm(42, 3'h6, 16'h0005);
    slow <= 0;
    $display("test priority done");
    sok <= 0;
    xtr(8'h10, 16'h0007);
    #1 chk({31'h0, drop}, 32'h1);
    sok <= 1;
    wrr(6'h24, 32'h0000_0000);
    xtr(8'h10, 16'h0008);
    #1 chk({31'h0, drop}, 32'h1);
    rc(6'h28, 32'h0000_0002);
    wrr(6'h24, 32'h0000_0041);
    xtr(8'h08, 16'h0009);
    waitn(57);
    chk(host.got[49][31:0], 32'h0000_000A);
    frm(50, 3'h3, 16'h0009);
    $display("test drop and port header done");
    wrr(6'h24, 32'h0000_0040);
    stall <= 1;
    xtr(8'h08, 16'h000A);
    repeat (5) @(posedge clk);
    rc(6'h30, 32'h0000_0029);
    rc(6'h2C, 32'hC1A5_000A);
    rc(6'h2C, 32'h0000_4A03);
    rc(6'h2C, 32'h0000_000A);
    repeat (4) rc(6'h2C, 32'h0000_0000);
    rc(6'h30, 32'h0000_0000);
    stall <= 0;
    $display("test register extraction done");
    inj(3'b011, {32'h0, 32'h557F_C010, 32'h0016_8062});
    chk({29'h0, av}, 32'h3);
    chk({20'h0, ad[11:0]}, 32'h008);
    chk({24'h0, aen[7:0]}, 32'h5A);
    chk({24'h0, aen[15:8]}, 32'h0);
    chk({20'h0, ad[23:12]}, 32'h155);
    chk({24'h0, ask[7:0]}, 32'h3);
    inj(3'b101, {32'h0000_0087, 32'h0, 32'h0000_0A08});
    chk({28'h0, asr[3:0]}, 32'h5);
    chk({31'h0, am[0]}, 32'h1);
    chk({31'h0, ab[2]}, 32'h1);
    chk({20'h0, ad[35:24]}, 32'h010);
    chk({24'h0, ask[23:16]}, 32'h7F);
    inj(3'b010, {32'h0, 32'h0000_2000, 32'h0});
    chk({30'h0, at}, 32'h2);
    wrr(6'h38, 32'h0000_0020);
    t = 0;
    repeat (4)
    begin
      #1;
      if (av[1] === 1'b1)
        t = {20'h0, ad[23:12]};
      @(posedge clk);
    end
    chk(t, 32'h002);
    @(posedge clk);
    lv <= 1;
    li <= 16'hBEEF;
    @(posedge clk);
    lv <= 0;
    #1 chk({15'h0, rv, ri}, 32'h1_BEEF);
    $display("test inject done");
    end_of_test;
  end
  // Watchdog well past the expected run
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end
endmodule
